// ### src/mode_select_pkg.sv
package mode_select_pkg;
	// width of the strap code and of the mode number
	localparam int MODE_W = 3;
	// strap codes as seen on high, mid, low pins
	localparam logic [2:0] CODE_MODE4 = 3'h4;
	localparam logic [2:0] CODE_MODE5 = 3'h5;
	localparam logic [2:0] CODE_MODE6 = 3'h6;
	localparam logic [2:0] CODE_MODE7 = 3'h7;
	// reset values of the decoded outputs (single-chip is the safe state)
	localparam logic [2:0] RST_MODE_NUM = 3'h7;
	localparam logic       RST_ROM_EN   = 1'h1;
	localparam logic       RST_EXT_EN   = 1'h0;
	localparam logic       RST_WIDE_BUS = 1'h0;
	// number of address areas whose access width the bus controller sets
	localparam int AREA_CNT = 8;
	// operating modes
	typedef enum logic [1:0] {
		MODE_EXT16_NOROM,
		MODE_EXT8_NOROM,
		MODE_EXT8_ROM,
		MODE_SINGLE
	} op_mode_type;
endpackage : mode_select_pkg

// ### src/strap_sync.sv
`timescale 1ns/1ns
// three-stage synchroniser for the strap pins; a change counts once stages two and three agree
module strap_sync (
	input  wire logic       sys_clk, // system clock
	input  wire logic [2:0] pinIn,   // raw strap pins
	output logic      [2:0] pinOut   // filtered strap level
);
	// all synchroniser state
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] held;
	} sync_type;
	sync_type st_ff;
	sync_type nxt_st;

	// shift chain; first stage read only by the second
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = pinIn;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		// accept new level only when stages two and three agree
		if (st_ff.s2 == st_ff.s3) begin
			nxt_st.held = st_ff.s3;
		end
	end

	// register the state; no reset here, so the chain keeps tracking the straps
	// while the block is held in reset and is settled when reset is released
	always_ff @(posedge sys_clk) begin
		st_ff <= nxt_st;
	end

	assign pinOut = st_ff.held;
endmodule : strap_sync

// ### src/operating_mode_select.sv
`timescale 1ns/1ns
module operating_mode_select #(
	parameter bit SMALL_VARIANT = 1'b0 // product variant offering mode seven only
) (
	input  wire logic       sys_clk,     // system clock, 10 MHz
	input  wire logic       rst,         // power-on reset, async, active high
	input  wire logic       mode_pin_high, // strap pin, most significant
	input  wire logic       mode_pin_mid,  // strap pin, middle
	input  wire logic       mode_pin_low,  // strap pin, least significant
	input  wire logic       progStarted, // program execution has begun
	input  wire logic [7:0] areaWide,    // per-area 16-bit access setting
	output logic      [2:0] modeNum,     // latched mode number 4..7
	output logic            modeValid,   // mode latched after reset release
	output logic            advAddr,     // advanced addressing in use
	output logic            romEn,       // on-chip program memory enabled
	output logic            extEn,       // external address space reachable
	output logic            initWide,    // initial external bus is 16 bits
	output logic            maxWide,     // external bus may reach 16 bits
	output logic            busWide,     // present bus mode is 16-bit
	output logic            strapBad     // straps gave a code outside 4..7, full variant only
);
	// whole block state
	typedef struct packed {
		logic       inReset;
		logic       valid;
		logic [2:0] modeNum;
		logic       romEn;
		logic       extEn;
		logic       initWide;
		logic       bad;
		logic       busWide;
	} state_type;
	state_type st_ff;
	state_type nxt_st;
	logic [2:0] strapLvl; // synchronised strap code

	// strap synchroniser; it runs through reset, so the code that is latched
	// on release is the one that stood on the pins while reset was held
	strap_sync syncInst (
		.sys_clk (sys_clk),
		.pinIn   ({mode_pin_high, mode_pin_mid, mode_pin_low}),
		.pinOut  (strapLvl)
	);

	// map a strap code to a mode, small variant forced to single-chip
	function automatic mode_select_pkg::op_mode_type decode_mode(input logic [2:0] code);
		if (SMALL_VARIANT) begin
			return mode_select_pkg::MODE_SINGLE;
		end
		// the high pin is not decoded: a code below four acts like its twin
		// above four, and the latch raises strapBad for it
		unique case ({1'b1, code[1:0]})
			mode_select_pkg::CODE_MODE4: return mode_select_pkg::MODE_EXT16_NOROM;
			mode_select_pkg::CODE_MODE5: return mode_select_pkg::MODE_EXT8_NOROM;
			mode_select_pkg::CODE_MODE6: return mode_select_pkg::MODE_EXT8_ROM;
			default: return mode_select_pkg::MODE_SINGLE;
		endcase
	endfunction : decode_mode

	mode_select_pkg::op_mode_type decMode; // mode from present straps
	assign decMode = decode_mode(strapLvl);

	// next-state logic: latch once on first cycle after reset, then track bus width
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.inReset = 1'b0;
		if (st_ff.inReset) begin
			// first clock after release: capture decoded mode, later changes ignored
			nxt_st.valid    = 1'b1;
			nxt_st.bad      = (strapLvl[2] == 1'b0) && !SMALL_VARIANT;
			nxt_st.modeNum  = SMALL_VARIANT ? mode_select_pkg::CODE_MODE7
				: {1'b1, strapLvl[1:0]};
			nxt_st.romEn    = (decMode == mode_select_pkg::MODE_EXT8_ROM)
				|| (decMode == mode_select_pkg::MODE_SINGLE);
			nxt_st.extEn    = (decMode != mode_select_pkg::MODE_SINGLE);
			nxt_st.initWide = (decMode == mode_select_pkg::MODE_EXT16_NOROM);
			nxt_st.busWide  = nxt_st.initWide;
		end else if (st_ff.valid && st_ff.extEn && progStarted) begin
			// bus width follows the area settings after execution starts
			nxt_st.busWide = |areaWide;
		end
	end

	// register the state; straps sampled by synchroniser during reset
	// reset values put the block in the safe single-chip state until the latch
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff          <= '0;
			st_ff.inReset  <= 1'b1;
			st_ff.modeNum  <= mode_select_pkg::RST_MODE_NUM;
			st_ff.romEn    <= mode_select_pkg::RST_ROM_EN;
			st_ff.extEn    <= mode_select_pkg::RST_EXT_EN;
			st_ff.busWide  <= mode_select_pkg::RST_WIDE_BUS;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from state, except advAddr which is tied high
	assign modeNum   = st_ff.modeNum;
	assign modeValid = st_ff.valid;
	assign advAddr   = 1'b1; // every mode uses advanced addressing
	assign romEn     = st_ff.romEn;
	assign extEn     = st_ff.extEn;
	assign initWide  = st_ff.initWide;
	assign maxWide   = st_ff.extEn;
	assign busWide   = st_ff.busWide;
	assign strapBad  = st_ff.bad;

	// checks on the decoded outputs; all are quiet while reset is held
	// except the reset check, which looks one edge past a sampled reset

	// latched mode never changes once valid
	a_mode_held: assert property (
		@(posedge sys_clk) disable iff (rst)
		$past(st_ff.valid)
		|-> $stable(modeNum)
	) else $error("mode changed after latch");

	// single-chip never exposes external space
	a_single_noext: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && modeNum == mode_select_pkg::CODE_MODE7
		|-> !extEn && romEn
	) else $error("mode 7 wrong");

	// modes four and five disable rom
	a_nrom_modes: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && modeNum[2:1] == 2'h2
		|-> !romEn && extEn
	) else $error("mode 4/5 wrong");

	// mode six rom on, narrow start
	a_mode_six: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && modeNum == mode_select_pkg::CODE_MODE6
		|-> romEn && extEn && !initWide
	) else $error("mode 6 wrong");

	// external access in extended modes
	a_ext_allowed: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && modeNum != mode_select_pkg::CODE_MODE7
		|-> extEn && maxWide
	) else $error("ext not allowed");

	// any wide area makes bus wide next cycle
	a_wide_bus: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && extEn && progStarted && (|areaWide)
		|=> busWide
	) else $error("bus not wide");

	// all narrow areas make bus narrow
	a_narrow_bus: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && extEn && progStarted && areaWide == 8'h00
		|=> !busWide
	) else $error("bus not narrow");

	// small variant only mode seven
	a_small_only: assert property (
		@(posedge sys_clk) disable iff (rst)
		SMALL_VARIANT && modeValid
		|-> modeNum == mode_select_pkg::CODE_MODE7
	) else $error("variant mode wrong");

	// valid rises exactly one cycle after release
	a_latch_once: assert property (
		@(posedge sys_clk) disable iff (rst)
		$rose(modeValid)
		|-> $past(st_ff.inReset)
	) else $error("late latch");

	// one edge after a sampled reset the outputs show the safe state
	a_reset_state: assert property (
		@(posedge sys_clk)
		rst
		|=> !modeValid && modeNum == mode_select_pkg::RST_MODE_NUM && romEn == mode_select_pkg::RST_ROM_EN
			&& extEn == mode_select_pkg::RST_EXT_EN && busWide == mode_select_pkg::RST_WIDE_BUS
	) else $error("reset state wrong");

	// only mode four starts on a 16-bit bus
	a_init_mode: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && initWide
		|-> modeNum == mode_select_pkg::CODE_MODE4
	) else $error("wide start outside mode 4");

	// without external space the bus stays narrow
	a_single_narrow: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && !extEn
		|-> !busWide && !maxWide && !initWide
	) else $error("bus wide in single-chip");

	// bus width holds until execution has started
	a_idle_width: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid && !progStarted
		|=> $stable(busWide)
	) else $error("bus width moved before start");

	// once latched the mode stays valid until the next reset
	a_valid_stays: assert property (
		@(posedge sys_clk) disable iff (rst)
		modeValid
		|=> modeValid
	) else $error("mode valid dropped");

	// small variant never flags a strap code nor opens external space
	a_small_clean: assert property (
		@(posedge sys_clk) disable iff (rst)
		SMALL_VARIANT && modeValid
		|-> !strapBad && !extEn
	) else $error("variant flags wrong");
endmodule : operating_mode_select

// ### testbench/strap_board.sv
`timescale 1ns/1ns
// board straps: the bench picks a code and the board drives it onto the pins
module strap_board (
	input  wire logic [2:0] code,    // strap code chosen by the bench
	output logic            pinHigh, // strap level, most significant
	output logic            pinMid,  // strap level, middle
	output logic            pinLow   // strap level, least significant
);
	// straps follow the chosen code, also when the bench changes it while running
	assign pinHigh = code[2];
	assign pinMid  = code[1];
	assign pinLow  = code[0];
endmodule : strap_board

// ### testbench/tb_operating_mode_select.sv
`timescale 1ns/1ns
module tb_operating_mode_select;
	logic       sysClk, rst, pHigh, pMid, pLow, progStarted;  // clock, reset, straps, run
	logic [7:0] areaWide;                                     // per-area width setting
	logic [2:0] code, modeNum;                                // strap code, latched mode
	logic       modeValid, advAddr, romEn, extEn, initWide, maxWide, busWide, strapBad;
	int         errTotal = 0, samplesChecked = 0, cycles = 0; // counters
	// rows: strap code, then mode, rom, ext, initWide, maxWide, busWide, strapBad
	logic [11:0] rows [6] = '{12'h91e, 12'hb54, 12'hdb4, 12'hfe0, 12'h7e1, 12'h11f};
	logic [2:0] smallMode;                                  // small variant latched mode
	logic       smallValid, smallRom, smallExt, smallBad;   // small variant flags
	wire  [9:0] outVec = {modeValid, modeNum, romEn, extEn, initWide, maxWide,
		busWide, strapBad};                                 // main outputs in row order
	wire  [9:0] smallVec = {smallValid, smallMode, smallRom, smallExt, smallBad, 3'h0};
	strap_board board (.code(code), .pinHigh(pHigh), .pinMid(pMid), .pinLow(pLow));
	operating_mode_select uut (.sys_clk(sysClk), .rst(rst), .mode_pin_high(pHigh),
		.mode_pin_mid(pMid), .mode_pin_low(pLow), .progStarted(progStarted),
		.areaWide(areaWide), .modeNum(modeNum), .modeValid(modeValid), .advAddr(advAddr),
		.romEn(romEn), .extEn(extEn), .initWide(initWide), .maxWide(maxWide),
		.busWide(busWide), .strapBad(strapBad));
	// small product variant on the same straps
	operating_mode_select #(.SMALL_VARIANT(1'b1)) uutSmall (.sys_clk(sysClk), .rst(rst),
		.mode_pin_high(pHigh), .mode_pin_mid(pMid), .mode_pin_low(pLow),
		.progStarted(progStarted), .areaWide(areaWide), .modeNum(smallMode),
		.modeValid(smallValid), .advAddr(), .romEn(smallRom), .extEn(smallExt),
		.initWide(), .maxWide(), .busWide(), .strapBad(smallBad));
	// clock generator, 100 ns period
	initial begin
		sysClk = 1'h0;
		forever #50 sysClk = ~sysClk;
	end
	// hang guard
	always @(posedge sysClk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errTotal++;
			testDone();
		end
	end
	// one comparison of a result vector
	task chk(input logic [9:0] got, input logic [9:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// reset with the given straps, release, let the latch settle
	task doReset(input logic [2:0] c);
		@(posedge sysClk);
		rst  <= 1'h1;
		code <= c;
		repeat (10) @(posedge sysClk);
		#1 chk({9'h0, modeValid}, 10'h0);
		@(posedge sysClk);
		rst <= 1'h0;
		repeat (3) @(posedge sysClk);
		#1;
	endtask : doReset
	// verdict
	task testDone();
		$display("mismatches %0d comparisons %0d", errTotal, samplesChecked);
		if (errTotal == 0 && samplesChecked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : testDone
	// main sequence
	initial begin
		rst = 1'h1;
		code = 3'h7;
		progStarted = 1'h0;
		areaWide = 8'h00;
		for (int i = 0; i < 6; i++) begin
			doReset(rows[i][11:9]);
			chk(outVec, {1'h1, rows[i][8:0]});
			chk(smallVec, 10'h3e0);
			chk({9'h0, advAddr}, 10'h1);
		end
		// mode five: one wide area turns the bus to 16 bits
		doReset(3'h5);
		@(posedge sysClk);
		progStarted <= 1'h1;
		areaWide    <= 8'h80;
		repeat (2) @(posedge sysClk);
		#1 chk({9'h0, busWide}, 10'h1);
		@(posedge sysClk);
		areaWide <= 8'h00;
		repeat (2) @(posedge sysClk);
		#1 chk({9'h0, busWide}, 10'h0);
		// straps moved while running are ignored
		@(posedge sysClk);
		code <= 3'h4;
		repeat (6) @(posedge sysClk);
		#1 chk(outVec, 10'h354);
		// single-chip: wide areas have no effect
		@(posedge sysClk);
		areaWide <= 8'hff;
		doReset(3'h7);
		repeat (2) @(posedge sysClk);
		#1 chk({8'h0, extEn, busWide}, 10'h0);
		testDone();
	end
endmodule : tb_operating_mode_select
